// ### hw/lsb_pkg.sv
// package: operation codes, sizes and constants of the logic/shift/bit unit
package lsb_pkg;

  // datapath widths
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 3;

  // operand size masks and sign-bit positions
  localparam logic [31:0] MASK_BYTE = 32'h000000FF;
  localparam logic [31:0] MASK_WORD = 32'h0000FFFF;
  localparam logic [31:0] MASK_LONG = 32'hFFFFFFFF;
  localparam logic [31:0] TOP_BYTE = 32'h00000080;
  localparam logic [31:0] TOP_WORD = 32'h00008000;
  localparam logic [31:0] TOP_LONG = 32'h80000000;

  // reset values of the result, flag, memory write-data and bit-index registers
  localparam logic [31:0] RESET_DATA = 32'h00000000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_FLAGS = 4'h0;
  localparam logic [2:0] RESET_IDX = 3'h0;

  // positions in the flag vector {n, z, v, c}
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;

  // operand size
  typedef enum logic [1:0] {
    size_byte,
    size_word,
    size_long
  } lsb_size_type;

  // operation selected by the decoder
  typedef enum logic [4:0] {
    and_op,
    or_op,
    xor_op,
    not_op,
    arith_shift_left_op,
    arith_shift_right_op,
    logic_shift_left_op,
    logic_shift_right_op,
    rotate_left_op,
    rotate_right_op,
    rotate_carry_left_op,
    rotate_carry_right_op,
    bit_force_one_op,
    bit_force_zero_op,
    bit_toggle_op,
    bit_probe_op,
    carry_and_bit_op,
    carry_and_inv_bit_op,
    carry_or_bit_op,
    carry_or_inv_bit_op
  } lsb_op_type;

  // mask of the bits that belong to an operand of the given size
  function automatic logic [31:0] lsb_size_mask(lsb_size_type s);
    case (s)
      size_byte: return MASK_BYTE;
      size_word: return MASK_WORD;
      default: return MASK_LONG;
    endcase
  endfunction : lsb_size_mask

  // sign bit of an operand of the given size
  function automatic logic [31:0] lsb_size_top(lsb_size_type s);
    case (s)
      size_byte: return TOP_BYTE;
      size_word: return TOP_WORD;
      default: return TOP_LONG;
    endcase
  endfunction : lsb_size_top

endpackage : lsb_pkg

// ### hw/lsb_shift_rot.sv
// two-stage shifter and rotator for byte, word and longword operands
`timescale 1ns/10ps
`default_nettype none
module lsb_shift_rot (
  input wire lsb_pkg::lsb_op_type op_i,
  input wire lsb_pkg::lsb_size_type size_i,
  input wire logic two_i,
  input wire logic [31:0] value_i,
  input wire logic carry_i,
  output logic [31:0] result_o,
  output logic carry_o,
  output logic ovf_o
);

  logic [31:0] size_m;
  logic [31:0] top_m;
  logic [31:0] step_v [0:2];
  logic [2:0] step_c;
  logic [2:0] step_o;

  // stage 0 is the operand cut to its size
  assign size_m = lsb_pkg::lsb_size_mask(size_i);
  assign top_m = lsb_pkg::lsb_size_top(size_i);
  assign step_v[0] = value_i & size_m;
  assign step_c[0] = carry_i;
  assign step_o[0] = 1'b0;

  // one single-position step per stage
  genvar g;
  for (g = 0; g < 2; g++)
  begin : g_step
    logic msb;
    logic new_msb;
    logic left;
    logic fill;
    logic [31:0] shl;
    logic [31:0] shr;

    assign msb = |(step_v[g] & top_m);
    assign shl = {step_v[g][30:0], 1'b0} & size_m;
    assign shr = {1'b0, step_v[g][31:1]};
    assign new_msb = |(shl & top_m);

    // direction and bit that enters the vacated end
    always_comb
    begin
      left = 1'b0;
      fill = 1'b0;
      case (op_i)
        lsb_pkg::arith_shift_left_op: left = 1'b1;
        lsb_pkg::logic_shift_left_op: left = 1'b1;
        lsb_pkg::rotate_left_op:
        begin
          left = 1'b1;
          fill = msb;
        end
        lsb_pkg::rotate_carry_left_op:
        begin
          left = 1'b1;
          fill = step_c[g];
        end
        lsb_pkg::arith_shift_right_op: fill = msb;
        lsb_pkg::rotate_right_op: fill = step_v[g][0];
        lsb_pkg::rotate_carry_right_op: fill = step_c[g];
        default: fill = 1'b0; // logical right shifts in zero
      endcase
    end

    // carry takes the bit that left the operand
    assign step_v[g+1] = left ? (shl | {31'h0, fill})
                              : (shr | (fill ? top_m : 32'h0));
    assign step_c[g+1] = left ? msb : step_v[g][0];
    assign step_o[g+1] = step_o[g] | (left & (msb ^ new_msb));
  end

  // one or two positions
  assign result_o = two_i ? step_v[2] : step_v[1];
  assign carry_o = two_i ? step_c[2] : step_c[1];
  assign ovf_o = (op_i == lsb_pkg::arith_shift_left_op) &
                 (two_i ? step_o[2] : step_o[1]);

endmodule : lsb_shift_rot
`default_nettype wire

// ### hw/lsb_bit_op.sv
// single-bit manipulation of one byte, with carry and zero flag effects
`timescale 1ns/10ps
`default_nettype none
module lsb_bit_op (
  input wire lsb_pkg::lsb_op_type op_i,
  input wire logic [7:0] byte_i,
  input wire logic [2:0] idx_i,
  input wire logic carry_i,
  output logic [7:0] byte_o,
  output logic carry_o,
  output logic zero_o,
  output logic modify_o,
  output logic carry_we_o,
  output logic zero_we_o
);

  logic sel_bit;
  logic new_bit;

  assign sel_bit = byte_i[idx_i];
  assign zero_o = ~sel_bit;

  // effect of each bit operation
  always_comb
  begin
    new_bit = sel_bit;
    carry_o = carry_i;
    modify_o = 1'b0;
    carry_we_o = 1'b0;
    zero_we_o = 1'b0;
    case (op_i)
      lsb_pkg::bit_force_one_op:
      begin
        new_bit = 1'b1;
        modify_o = 1'b1;
      end
      lsb_pkg::bit_force_zero_op:
      begin
        new_bit = 1'b0;
        modify_o = 1'b1;
      end
      lsb_pkg::bit_toggle_op:
      begin
        new_bit = ~sel_bit;
        modify_o = 1'b1;
      end
      lsb_pkg::bit_probe_op: zero_we_o = 1'b1;
      lsb_pkg::carry_and_bit_op:
      begin
        carry_o = carry_i & sel_bit;
        carry_we_o = 1'b1;
      end
      lsb_pkg::carry_and_inv_bit_op:
      begin
        carry_o = carry_i & ~sel_bit;
        carry_we_o = 1'b1;
      end
      lsb_pkg::carry_or_bit_op:
      begin
        carry_o = carry_i | sel_bit;
        carry_we_o = 1'b1;
      end
      lsb_pkg::carry_or_inv_bit_op:
      begin
        carry_o = carry_i | ~sel_bit;
        carry_we_o = 1'b1;
      end
      default: modify_o = 1'b0;
    endcase
  end

  // only the indexed bit may change
  genvar g;
  for (g = 0; g < 8; g++)
  begin : g_bit
    assign byte_o[g] = (idx_i == 3'(g)) ? new_bit : byte_i[g];
  end

endmodule : lsb_bit_op
`default_nettype wire

// ### hw/lsb_unit.sv
// logic, shift/rotate and bit manipulation slice of the cpu datapath
`timescale 1ns/10ps
`default_nettype none

module lsb_unit (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire lsb_pkg::lsb_op_type op_i,
  input wire lsb_pkg::lsb_size_type size_i,
  input wire logic two_i,
  input wire logic [31:0] dst_i,
  input wire logic [31:0] src_gpr_i,
  input wire logic [31:0] imm_i,
  input wire logic use_imm_i,
  input wire logic [2:0] bit_imm_i,
  input wire logic bit_idx_reg_i,
  input wire logic mem_op_i,
  input wire logic carry_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] result_o,
  output logic result_we_o,
  output logic [3:0] flags_o,
  output logic [3:0] flags_we_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o
);

  // sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_mem_wait
  } lsb_state_type;

  // all state of the unit
  typedef struct packed {
    logic [1:0] rst_sync;
    lsb_state_type fsm;
    lsb_pkg::lsb_op_type op;
    logic [2:0] idx;
    logic carry;
    logic busy;
    logic done;
    logic [31:0] result;
    logic result_we;
    logic [3:0] flags;
    logic [3:0] flags_we;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
  } lsb_state_rec_type;

  lsb_state_rec_type st_q;
  lsb_state_rec_type st_d;

  // decode helpers
  logic op_is_logic;
  logic op_is_shift;
  logic op_is_bit;
  logic idx_imm_only;
  logic [2:0] live_idx;
  logic [31:0] operand_b;
  logic [31:0] logic_calc;
  logic [31:0] size_m;
  logic [31:0] size_t;

  // shared sub-unit connections
  logic [31:0] shift_res;
  logic shift_c;
  logic shift_v;
  lsb_pkg::lsb_op_type bit_op;
  logic [7:0] bit_in;
  logic [2:0] bit_idx;
  logic bit_cin;
  logic [7:0] bit_res;
  logic bit_c;
  logic bit_z;
  logic bit_mod;
  logic bit_c_we;
  logic bit_z_we;

  // operation class
  assign op_is_logic = (op_i == lsb_pkg::and_op) ||
                       (op_i == lsb_pkg::or_op) ||
                       (op_i == lsb_pkg::xor_op) ||
                       (op_i == lsb_pkg::not_op);
  assign op_is_shift = (op_i >= lsb_pkg::arith_shift_left_op) &&
                       (op_i <= lsb_pkg::rotate_carry_right_op);
  assign op_is_bit = (op_i >= lsb_pkg::bit_force_one_op);

  // inverted carry ops take their index from the immediate only
  assign idx_imm_only = (op_i == lsb_pkg::carry_and_inv_bit_op) ||
                        (op_i == lsb_pkg::carry_or_inv_bit_op);
  assign live_idx = (bit_idx_reg_i && !idx_imm_only) ?
                    src_gpr_i[2:0] : bit_imm_i;

  // second operand: register or immediate
  assign operand_b = use_imm_i ? imm_i : src_gpr_i;
  assign size_m = lsb_pkg::lsb_size_mask(size_i);
  assign size_t = lsb_pkg::lsb_size_top(size_i);

  // bitwise logic result
  always_comb
  begin
    case (op_i)
      lsb_pkg::and_op: logic_calc = dst_i & operand_b;
      lsb_pkg::or_op: logic_calc = dst_i | operand_b;
      lsb_pkg::xor_op: logic_calc = dst_i ^ operand_b;
      lsb_pkg::not_op: logic_calc = ~dst_i;
      default: logic_calc = dst_i;
    endcase
  end

  // shift and rotate datapath
  lsb_shift_rot u_shift (
    .op_i(op_i),
    .size_i(size_i),
    .two_i(two_i),
    .value_i(dst_i),
    .carry_i(carry_i),
    .result_o(shift_res),
    .carry_o(shift_c),
    .ovf_o(shift_v)
  );

  // bit unit sees the register byte when idle, the memory byte later
  assign bit_op = (st_q.fsm == st_mem_wait) ? st_q.op : op_i;
  assign bit_in = (st_q.fsm == st_mem_wait) ? mem_rdata_i : dst_i[7:0];
  assign bit_idx = (st_q.fsm == st_mem_wait) ? st_q.idx : live_idx;
  assign bit_cin = (st_q.fsm == st_mem_wait) ? st_q.carry : carry_i;

  lsb_bit_op u_bit (
    .op_i(bit_op),
    .byte_i(bit_in),
    .idx_i(bit_idx),
    .carry_i(bit_cin),
    .byte_o(bit_res),
    .carry_o(bit_c),
    .zero_o(bit_z),
    .modify_o(bit_mod),
    .carry_we_o(bit_c_we),
    .zero_we_o(bit_z_we)
  );

  // next state
  always_comb
  begin
    st_d = st_q;
    st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
    st_d.done = 1'b0;
    st_d.result_we = 1'b0;
    st_d.flags_we = lsb_pkg::RESET_FLAGS;
    st_d.mem_rd = 1'b0;
    st_d.mem_wr = 1'b0;
    case (st_q.fsm)
      st_idle:
      begin
        if (req_i)
        begin
          if (op_is_bit && mem_op_i)
          begin
            // start of the memory byte sequence
            st_d.op = op_i;
            st_d.idx = live_idx;
            st_d.carry = carry_i;
            st_d.mem_rd = 1'b1;
            st_d.busy = 1'b1;
            st_d.fsm = st_mem_wait;
          end
          else if (op_is_logic)
          begin
            // upper bits outside the size are kept
            st_d.result = (dst_i & ~size_m) |
                          (logic_calc & size_m);
            st_d.result_we = 1'b1;
            st_d.flags[lsb_pkg::FLAG_N] = |(logic_calc & size_t);
            st_d.flags[lsb_pkg::FLAG_Z] = ~|(logic_calc & size_m);
            st_d.flags[lsb_pkg::FLAG_V] = 1'b0;
            st_d.flags_we[lsb_pkg::FLAG_N] = 1'b1;
            st_d.flags_we[lsb_pkg::FLAG_Z] = 1'b1;
            st_d.flags_we[lsb_pkg::FLAG_V] = 1'b1;
            st_d.done = 1'b1;
          end
          else if (op_is_shift)
          begin
            st_d.result = (dst_i & ~size_m) | shift_res;
            st_d.result_we = 1'b1;
            st_d.flags[lsb_pkg::FLAG_N] = |(shift_res & size_t);
            st_d.flags[lsb_pkg::FLAG_Z] = ~|shift_res;
            st_d.flags[lsb_pkg::FLAG_V] = shift_v;
            st_d.flags[lsb_pkg::FLAG_C] = shift_c;
            st_d.flags_we = 4'hF;
            st_d.done = 1'b1;
          end
          else
          begin
            // register bit operation on the low byte
            st_d.result = {dst_i[31:8], bit_res};
            st_d.result_we = bit_mod;
            st_d.flags[lsb_pkg::FLAG_Z] = bit_z;
            st_d.flags[lsb_pkg::FLAG_C] = bit_c;
            st_d.flags_we[lsb_pkg::FLAG_Z] = bit_z_we;
            st_d.flags_we[lsb_pkg::FLAG_C] = bit_c_we;
            st_d.done = 1'b1;
          end
        end
      end
      st_mem_wait:
      begin
        if (mem_rvalid_i)
        begin
          // for set, clear and toggle the whole byte goes back with only the one bit changed; probe and carry ops write nothing
          st_d.mem_wdata = bit_res;
          st_d.mem_wr = bit_mod;
          st_d.flags[lsb_pkg::FLAG_Z] = bit_z;
          st_d.flags[lsb_pkg::FLAG_C] = bit_c;
          st_d.flags_we[lsb_pkg::FLAG_Z] = bit_z_we;
          st_d.flags_we[lsb_pkg::FLAG_C] = bit_c_we;
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
          st_d.fsm = st_idle;
        end
      end
      default: st_d.fsm = st_idle;
    endcase
    // internal reset held until the synchroniser releases
    if (!st_q.rst_sync[1])
    begin
      st_d.fsm = st_idle;
      st_d.op = lsb_pkg::and_op;
      st_d.idx = lsb_pkg::RESET_IDX;
      st_d.carry = 1'b0;
      st_d.busy = 1'b0;
      st_d.done = 1'b0;
      st_d.result = lsb_pkg::RESET_DATA;
      st_d.result_we = 1'b0;
      st_d.flags = lsb_pkg::RESET_FLAGS;
      st_d.flags_we = lsb_pkg::RESET_FLAGS;
      st_d.mem_rd = 1'b0;
      st_d.mem_wr = 1'b0;
      st_d.mem_wdata = lsb_pkg::RESET_BYTE;
    end
  end

  // state register, constants only under asynchronous reset
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q.rst_sync <= 2'h0;
      st_q.fsm <= st_idle;
      st_q.op <= lsb_pkg::and_op;
      st_q.idx <= lsb_pkg::RESET_IDX;
      st_q.carry <= 1'b0;
      st_q.busy <= 1'b0;
      st_q.done <= 1'b0;
      st_q.result <= lsb_pkg::RESET_DATA;
      st_q.result_we <= 1'b0;
      st_q.flags <= lsb_pkg::RESET_FLAGS;
      st_q.flags_we <= lsb_pkg::RESET_FLAGS;
      st_q.mem_rd <= 1'b0;
      st_q.mem_wr <= 1'b0;
      st_q.mem_wdata <= lsb_pkg::RESET_BYTE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign busy_o = st_q.busy;
  assign done_o = st_q.done;
  assign result_o = st_q.result;
  assign result_we_o = st_q.result_we;
  assign flags_o = st_q.flags;
  assign flags_we_o = st_q.flags_we;
  assign mem_rd_o = st_q.mem_rd;
  assign mem_wr_o = st_q.mem_wr;
  assign mem_wdata_o = st_q.mem_wdata;

endmodule : lsb_unit
`default_nettype wire

// ### tb/lsb_mem_model.sv
// memory byte model answering the unit's read and write strobes
`timescale 1ns/10ps
`default_nettype none
module lsb_mem_model (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [3:0] delay_i,
  input wire logic load_i,
  input wire logic [7:0] preset_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o
);
  logic [7:0] byte_q;
  logic [3:0] wait_q;
  // answer a read after delay_i extra cycles; idle data flips every cycle
  always_ff @(posedge clock_i)
  begin
    rvalid_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (load_i)
      byte_q <= preset_i;
    if (wr_i)
      byte_q <= wdata_i;
    if (wait_q == 4'h1 || (rd_i && delay_i == 4'h0))
    begin
      rvalid_o <= 1'b1;
      rdata_o <= byte_q;
    end
    if (rd_i)
      wait_q <= delay_i;
    else if (wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    if (!resetn_i)
    begin
      rdata_o <= 8'hC3;
      wait_q <= 4'h0;
    end
  end
endmodule : lsb_mem_model
`default_nettype wire

// ### tb/lsb_unit_monitor.sv
// port-level assertions of the logic/shift/bit unit
`timescale 1ns/10ps
`default_nettype none
module lsb_unit_monitor (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire lsb_pkg::lsb_op_type op_i,
  input wire lsb_pkg::lsb_size_type size_i,
  input wire logic [31:0] dst_i,
  input wire logic [31:0] src_gpr_i,
  input wire logic [31:0] imm_i,
  input wire logic use_imm_i,
  input wire logic [2:0] bit_imm_i,
  input wire logic bit_idx_reg_i,
  input wire logic mem_op_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [31:0] result_o,
  input wire logic result_we_o,
  input wire logic [3:0] flags_o,
  input wire logic [3:0] flags_we_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [7:0] mem_wdata_o
);
  logic bitk, rq, mq;
  logic [31:0] mask, opnd;
  logic [2:0] idx;
  // request decode as the unit sees it, except idx of the inverted carry ops, which the unit takes from the immediate
  assign bitk = op_i >= lsb_pkg::bit_force_one_op;
  assign rq = req_i && !busy_o && !(mem_op_i && bitk);
  assign mq = req_i && !busy_o && mem_op_i && bitk;
  assign mask = (size_i == lsb_pkg::size_byte) ? 32'h000000FF :
    (size_i == lsb_pkg::size_word) ? 32'h0000FFFF : 32'hFFFFFFFF;
  assign opnd = use_imm_i ? imm_i : src_gpr_i;
  assign idx = bit_idx_reg_i ? src_gpr_i[2:0] : bit_imm_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // register operations and their results
  chk_and_value: assert property (rq && op_i == lsb_pkg::and_op |=>
    result_we_o && result_o == $past(dst_i & (opnd | ~mask)))
    else $error("and result wrong");
  chk_or_value: assert property (rq && op_i == lsb_pkg::or_op |=>
    done_o && result_o == $past(dst_i | (opnd & mask)))
    else $error("or result wrong");
  chk_xor_value: assert property (rq && op_i == lsb_pkg::xor_op |=>
    result_o == $past(dst_i ^ (opnd & mask))) else $error("xor wrong");
  chk_not_value: assert property (rq && op_i == lsb_pkg::not_op |=>
    result_o == $past(dst_i ^ mask)) else $error("complement wrong");
  chk_shift_flags: assert property (rq && op_i inside
    {[lsb_pkg::arith_shift_left_op:lsb_pkg::rotate_carry_right_op]}
    |=> done_o && flags_we_o == 4'hF) else $error("shift flags missing");
  chk_probe_zero: assert property (rq && op_i == lsb_pkg::bit_probe_op
    |=> flags_we_o == 4'h4 && !result_we_o && flags_o[2] != $past(dst_i[idx]))
    else $error("probe zero flag wrong");
  // memory read-modify-write sequence
  chk_mem_read: assert property (mq |=> mem_rd_o && busy_o)
    else $error("memory read not started");
  chk_mem_finish: assert property (busy_o && mem_rvalid_i |=>
    done_o && !busy_o) else $error("memory op not finished");
  chk_toggle_wb: assert property (busy_o && mem_rvalid_i &&
    op_i == lsb_pkg::bit_toggle_op |=> mem_wr_o &&
    mem_wdata_o == $past(mem_rdata_i ^ (8'h01 << idx)))
    else $error("toggle write-back wrong");
  chk_probe_nowr: assert property (busy_o && mem_rvalid_i &&
    op_i == lsb_pkg::bit_probe_op |=> !mem_wr_o) else $error("probe wrote");
endmodule : lsb_unit_monitor
bind lsb_unit lsb_unit_monitor i_lsb_unit_monitor (.clock_i, .resetn_i,
  .req_i, .op_i, .size_i, .dst_i, .src_gpr_i, .imm_i, .use_imm_i,
  .bit_imm_i, .bit_idx_reg_i, .mem_op_i, .mem_rdata_i, .mem_rvalid_i,
  .busy_o, .done_o, .result_o, .result_we_o, .flags_o, .flags_we_o,
  .mem_rd_o, .mem_wr_o, .mem_wdata_o);
`default_nettype wire

// ### tb/lsb_unit_bench.sv
// self-checking bench of the logic/shift/bit unit
`timescale 1ns/10ps
`default_nettype none
module lsb_unit_bench;
  logic clock_i = 1'b0, resetn_i = 1'b0, req_i = 1'b0, two_i = 1'b0;
  logic use_imm_i = 1'b0, bit_idx_reg_i = 1'b0, mem_op_i = 1'b0;
  logic carry_i = 1'b0, load_q = 1'b0, mem_rvalid_i;
  lsb_pkg::lsb_op_type op_i = lsb_pkg::and_op;
  lsb_pkg::lsb_size_type size_i = lsb_pkg::size_byte;
  logic [31:0] dst_i = 32'h0, src_gpr_i = 32'h3C5AF00F;
  logic [31:0] imm_i = 32'h0FF096A5, result_o;
  logic [2:0] bit_imm_i = 3'h0;
  logic [7:0] preset_q = 8'h5A, mem_rdata_i, mem_wdata_o;
  logic [3:0] delay_q = 4'h0, flags_o, flags_we_o;
  logic busy_o, done_o, result_we_o, mem_rd_o, mem_wr_o;
  int fails = 0, cmp_count = 0, cycles = 0;
  // unit and its memory byte
  lsb_unit i_lsb_unit (.clock_i, .resetn_i, .req_i, .op_i, .size_i, .two_i,
    .dst_i, .src_gpr_i, .imm_i, .use_imm_i, .bit_imm_i, .bit_idx_reg_i,
    .mem_op_i, .carry_i, .mem_rdata_i, .mem_rvalid_i, .busy_o, .done_o,
    .result_o, .result_we_o, .flags_o, .flags_we_o, .mem_rd_o, .mem_wr_o,
    .mem_wdata_o);
  lsb_mem_model i_lsb_mem_model (.clock_i, .resetn_i, .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .delay_i(delay_q),
    .load_i(load_q), .preset_i(preset_q), .rdata_o(mem_rdata_i),
    .rvalid_o(mem_rvalid_i));
  // 250 MHz clock and hang guard
  initial
    forever #2 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      $display("unexpected cycle count expected below 5000 seen %0d", cycles);
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one request cycle; returns in the answer cycle
  task automatic go();
    req_i = 1'b1;
    @(negedge clock_i);
    req_i = 1'b0;
  endtask : go
  // stepwise shift model on an operand of w bits
  task automatic ref_sh(input int o, w, n, input logic [31:0] d,
    input logic ci, output logic [31:0] r, output logic [3:0] f);
    logic [31:0] v, m;
    logic c, vf, t;
    m = (w == 32) ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
    v = d & m;
    c = ci;
    vf = 1'b0;
    repeat (n)
    begin
      t = v[w-1];
      case (o)
        4, 6: {c, v} = {t, v << 1};
        5: {c, v} = {v[0], (v >> 1) | ({31'h0, t} << (w - 1))};
        7: {c, v} = {v[0], v >> 1};
        8: {c, v} = {t, (v << 1) | {31'h0, t}};
        9: {c, v} = {v[0], (v >> 1) | ({31'h0, v[0]} << (w - 1))};
        10: {c, v} = {t, (v << 1) | {31'h0, c}};
        default: {c, v} = {v[0], (v >> 1) | ({31'h0, c} << (w - 1))};
      endcase
      v = v & m;
      vf = vf | (o == 4 && v[w-1] != t);
    end
    r = (d & ~m) | v;
    f = {v[w-1], v == 32'h0, vf, c};
  endtask : ref_sh
  task automatic t_logic();
    logic [31:0] m, r;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge clock_i);
      op_i = lsb_pkg::lsb_op_type'(k % 4);
      size_i = lsb_pkg::lsb_size_type'(k / 4);
      use_imm_i = k[0];
      dst_i = (k % 4 == 2) ? src_gpr_i : 32'hA5C30F96;
      m = (k < 4) ? 32'hFF : (k < 8) ? 32'hFFFF : 32'hFFFFFFFF;
      r = use_imm_i ? imm_i : src_gpr_i;
      r = (k % 4 == 0) ? dst_i & r : (k % 4 == 1) ? dst_i | r : dst_i ^ r;
      r = ((k % 4 == 3) ? ~dst_i : r) & m;
      go();
      chk("logic result", (dst_i & ~m) | r, result_o);
      chk("logic write", 32'h3, {30'h0, done_o, result_we_o});
      chk("logic flags", {25'h0, 4'hE, (r & ~(m >> 1)) != 32'h0,
        r == 32'h0, 1'b0}, {25'h0, flags_we_o, flags_o[3:1]});
    end
    $display("logic test done");
  endtask : t_logic
  task automatic t_shift();
    logic [31:0] r;
    logic [3:0] f;
    for (int k = 0; k < 96; k++)
    begin
      @(negedge clock_i);
      op_i = lsb_pkg::lsb_op_type'(4 + k / 12);
      size_i = lsb_pkg::lsb_size_type'(k % 3);
      two_i = k[2];
      carry_i = k[3];
      dst_i = k[1] ? 32'h8421C3A5 : 32'h40004041;
      ref_sh(4 + k / 12, 8 << (k % 3), two_i ? 2 : 1, dst_i, carry_i, r, f);
      go();
      chk("shift result", r, result_o);
      chk("shift flags", {24'h0, 4'hF, f}, {24'h0, flags_we_o, flags_o});
    end
    $display("shift test done");
  endtask : t_shift
  task automatic t_bits();
    logic [2:0] n;
    logic [7:0] y;
    logic e;
    for (int k = 0; k < 32; k++)
    begin
      @(negedge clock_i);
      op_i = lsb_pkg::lsb_op_type'(12 + k / 4);
      size_i = lsb_pkg::size_long;
      bit_idx_reg_i = k[1];
      carry_i = k[0];
      bit_imm_i = 3'(k + k / 4);
      src_gpr_i = {29'h15555555, 3'(k / 4 + 5)};
      dst_i = 32'h12345A3C;
      n = (k[1] && op_i != 17 && op_i != 19) ? src_gpr_i[2:0] : bit_imm_i;
      y = dst_i[7:0];
      y[n] = (k < 4) ? 1'b1 : (k < 8) ? 1'b0 : ~y[n];
      e = (k < 16) ? ~dst_i[n] : (k < 20) ? carry_i & dst_i[n] :
        (k < 24) ? carry_i & ~dst_i[n] : carry_i | dst_i[n];
      e = (k / 4 == 6) ? carry_i | dst_i[n] : (k > 27) ? carry_i | ~dst_i[n] : e;
      go();
      chk("bit write", {31'h0, k < 12}, {31'h0, result_we_o});
      if (k < 12)
        chk("bit result", {dst_i[31:8], y}, result_o);
      else
        chk("bit flag", {27'h0, k < 16 ? 4'h4 : 4'h1, e},
          {27'h0, flags_we_o, k < 16 ? flags_o[2] : flags_o[0]});
    end
    $display("bit test done");
  endtask : t_bits
  task automatic t_mem();
    logic [7:0] y;
    logic e;
    int rd;
    for (int k = 0; k < 16; k++)
    begin
      @(negedge clock_i);
      op_i = lsb_pkg::lsb_op_type'(12 + k % 8);
      mem_op_i = 1'b1;
      bit_idx_reg_i = 1'b0;
      bit_imm_i = 3'(k + 1);
      carry_i = k[3];
      delay_q = (k < 8) ? 4'h0 : 4'h3;
      load_q = 1'b1;
      y = preset_q;
      y[bit_imm_i] = (k % 8 == 0) ? 1'b1 : (k % 8 == 1) ? 1'b0 : ~y[bit_imm_i];
      e = preset_q[bit_imm_i];
      e = (k % 8 == 4) ? carry_i & e : (k % 8 == 5) ? carry_i & ~e :
        (k % 8 == 6) ? carry_i | e : carry_i | ~e;
      // request held a second cycle while busy, which must be refused
      req_i = 1'b1;
      @(negedge clock_i);
      load_q = 1'b0;
      carry_i = ~carry_i; // carry must be the one taken with the request
      rd = 0;
      chk("memory read", 32'h3, {30'h0, mem_rd_o, busy_o});
      for (int i = 0; i < 20 && done_o !== 1'b1; i++)
      begin
        @(negedge clock_i);
        req_i = 1'b0;
        rd += mem_rd_o;
      end
      chk("memory done", {30'h0, 1'b1, k % 8 < 3},
        {30'h0, done_o, mem_wr_o});
      chk("refused request", 32'h0, rd);
      if (k % 8 < 3)
        chk("memory byte", {24'h0, y}, {24'h0, mem_wdata_o});
      else if (k % 8 == 3)
        chk("memory zero", {31'h0, ~preset_q[bit_imm_i]},
          {31'h0, flags_o[2]});
      else
        chk("memory carry", {31'h0, e},
          {31'h0, flags_o[0]});
    end
    $display("memory test done");
  endtask : t_mem
  // reset, then every scenario in turn
  initial
  begin
    repeat (10) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clock_i);
    t_logic();
    t_shift();
    t_bits();
    t_mem();
    stop_test();
  end
endmodule : lsb_unit_bench
`default_nettype wire
